/* File: design/clb_core_local_io.sv */
// Overview of operation
// [RULE1] core identity reads 0 for core 0 and 1 for core 1
// [RULE2] main pin input is read-only, 30 pin levels in bits 29:0
// [RULE3] flash pin input read-only, bits 5:0: clock, select, data 0-3
// [RULE4] level bit 1 drives pin high, 0 drives it low, both groups
// [RULE5] level registers read back stored value, not the pin levels
// [RULE6] same-cycle writes from both cores: core 0 first, then core 1
// [RULE7] main level set alias ORs written ones into the level register
// [RULE8] main level clear alias clears bits written as one
// [RULE9] main level toggle alias inverts bits written as one
// [RULE10] drive enable bit 1 makes pin output, 0 input; reset zero
// [RULE11] drive enable register reads back its stored value
// [RULE12] drive enable set, clear, toggle aliases act atomically
// [RULE13] flash level set, clear, toggle aliases act on bits 5:0
// [RULE14] reserved bits and write-only aliases read as zero
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module clb_core_local_io (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire clb_pkg::clb_wb_req_type core0_wb_i,
  output var clb_pkg::clb_wb_rsp_type core0_wb_o,
  input wire clb_pkg::clb_wb_req_type core1_wb_i,
  output var clb_pkg::clb_wb_rsp_type core1_wb_o,
  input wire logic [29:0] main_pin_in_i,
  input wire logic [5:0] flash_pin_in_i,
  output logic [29:0] main_pin_level_o,
  output logic [29:0] main_pin_drive_enable_o,
  output logic [5:0] flash_pin_level_o
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [31:0] byte_mask(
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] apply_write(
    input logic [31:0] cur,
    input logic [1:0] op,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [31:0] m;
    logic [31:0] d;
    m = byte_mask(sel);
    d = dat & m;
    case (op)
      clb_pkg::OP_WRITE: apply_write = (cur & ~m) | d;
      clb_pkg::OP_SET: apply_write = cur | d;
      clb_pkg::OP_CLEAR: apply_write = cur & ~d;
      clb_pkg::OP_TOGGLE: apply_write = cur ^ d;
      default: apply_write = cur;
    endcase
  endfunction

  function automatic logic hits_group(
    input logic [7:0] adr,
    input logic [3:0] grp
  );
    return (adr[7:4] == grp) && (adr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------
  // bus request view
  // ----------------------------------------
  clb_pkg::clb_wb_req_type req [2];
  clb_pkg::clb_bus_state_type state_ff [2];
  clb_pkg::clb_bus_state_type nxt_state [2];
  logic [31:0] rdat_ff [2];
  logic [31:0] nxt_rdat [2];
  logic take [2];
  logic wr [2];
  logic [31:0] main_level_ff;
  logic [31:0] main_drive_ff;
  logic [31:0] flash_level_ff;
  logic [31:0] nxt_main_level;
  logic [31:0] nxt_main_drive;
  logic [31:0] nxt_flash_level;

  assign req[0] = core0_wb_i;
  assign req[1] = core1_wb_i;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      take[c] = req[c].cyc && req[c].stb && (state_ff[c] == clb_pkg::CLB_IDLE);
      wr[c] = take[c] && req[c].we;
    end
  end

  // ----------------------------------------
  // bus handshake, one wait state
  // ----------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (state_ff[c])
        clb_pkg::CLB_IDLE: begin
          nxt_state[c] = take[c] ? clb_pkg::CLB_ACK : clb_pkg::CLB_IDLE;
        end
        clb_pkg::CLB_ACK: begin
          nxt_state[c] = clb_pkg::CLB_IDLE;
        end
        default: begin
          nxt_state[c] = clb_pkg::CLB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (rst_i) begin
        state_ff[c] <= clb_pkg::CLB_IDLE;
      end else begin
        state_ff[c] <= nxt_state[c];
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (req[c].adr)
        clb_pkg::OFS_CORE_IDENTITY: begin
          nxt_rdat[c] = (c == 0) ? clb_pkg::CORE0_ID : clb_pkg::CORE1_ID; // [RULE1]
        end
        clb_pkg::OFS_MAIN_PIN_INPUT: begin
          nxt_rdat[c] = {2'b00, main_pin_in_i}; // [RULE2]
        end
        clb_pkg::OFS_FLASH_PIN_INPUT: begin
          nxt_rdat[c] = {26'h0, flash_pin_in_i}; // [RULE3]
        end
        clb_pkg::OFS_MAIN_PIN_LEVEL: begin
          nxt_rdat[c] = main_level_ff; // [RULE5]
        end
        clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE: begin
          nxt_rdat[c] = main_drive_ff; // [RULE11]
        end
        clb_pkg::OFS_FLASH_PIN_LEVEL: begin
          nxt_rdat[c] = flash_level_ff; // [RULE5]
        end
        default: begin
          nxt_rdat[c] = clb_pkg::UNMAPPED_DATA; // [RULE14]
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (rst_i) begin
        rdat_ff[c] <= clb_pkg::UNMAPPED_DATA;
      end else if (take[c] && !req[c].we) begin
        rdat_ff[c] <= nxt_rdat[c];
      end else if (take[c]) begin
        rdat_ff[c] <= clb_pkg::UNMAPPED_DATA;
      end
    end
  end

  assign core0_wb_o = '{ack: (state_ff[0] == clb_pkg::CLB_ACK), dat: rdat_ff[0]};
  assign core1_wb_o = '{ack: (state_ff[1] == clb_pkg::CLB_ACK), dat: rdat_ff[1]};

  // ----------------------------------------
  // register updates, core 0 applied first
  // ----------------------------------------
  always_comb begin
    nxt_main_level = main_level_ff;
    nxt_main_drive = main_drive_ff;
    nxt_flash_level = flash_level_ff;
    for (int c = 0; c < 2; c++) begin // [RULE6]
      if (wr[c] && hits_group(req[c].adr, clb_pkg::GRP_MAIN_LEVEL)) begin
        nxt_main_level = apply_write(nxt_main_level, req[c].adr[3:2],
          req[c].dat, req[c].sel); // [RULE7] [RULE8] [RULE9]
      end
      if (wr[c] && hits_group(req[c].adr, clb_pkg::GRP_MAIN_DRIVE)) begin
        nxt_main_drive = apply_write(nxt_main_drive, req[c].adr[3:2],
          req[c].dat, req[c].sel); // [RULE12]
      end
      if (wr[c] && hits_group(req[c].adr, clb_pkg::GRP_FLASH_LEVEL)) begin
        nxt_flash_level = apply_write(nxt_flash_level, req[c].adr[3:2],
          req[c].dat, req[c].sel); // [RULE13]
      end
    end
    nxt_main_level = nxt_main_level & clb_pkg::MAIN_MASK; // [RULE14]
    nxt_main_drive = nxt_main_drive & clb_pkg::MAIN_MASK;
    nxt_flash_level = nxt_flash_level & clb_pkg::FLASH_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_level_ff <= clb_pkg::LEVEL_RESET;
    end else begin
      main_level_ff <= nxt_main_level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_drive_ff <= clb_pkg::DRIVE_RESET; // [RULE10]
    end else begin
      main_drive_ff <= nxt_main_drive;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_level_ff <= clb_pkg::LEVEL_RESET;
    end else begin
      flash_level_ff <= nxt_flash_level;
    end
  end

  // ----------------------------------------
  // pin side
  // ----------------------------------------
  assign main_pin_level_o = main_level_ff[29:0]; // [RULE4]
  assign main_pin_drive_enable_o = main_drive_ff[29:0]; // [RULE10]
  assign flash_pin_level_o = flash_level_ff[5:0]; // [RULE4]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic rd0;
  logic rd1;
  logic full0;
  logic full1;
  logic solo0;
  assign rd0 = take[0] && !req[0].we;
  assign rd1 = take[1] && !req[1].we;
  assign full0 = wr[0] && (req[0].sel == 4'hf);
  assign full1 = wr[1] && (req[1].sel == 4'hf);
  assign solo0 = full0 && !wr[1];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_timing: assert property ( // ack one cycle after the request, one wait state
    take[0] |=> core0_wb_o.ack ##1 !core0_wb_o.ack)
    else $error("ack not one cycle after request");
  chk_core_id_one: assert property ( // [RULE1]
    rd1 && req[1].adr == clb_pkg::OFS_CORE_IDENTITY |=> core1_wb_o.dat == 32'h1)
    else $error("core 1 identity wrong");
  chk_core_id_zero: assert property ( // [RULE1]
    rd0 && req[0].adr == clb_pkg::OFS_CORE_IDENTITY |=> core0_wb_o.dat == 32'h0)
    else $error("core 0 identity wrong");
  chk_main_input_read: assert property ( // [RULE2]
    rd0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_INPUT
    |=> core0_wb_o.dat == {2'b00, $past(main_pin_in_i)})
    else $error("main input read wrong");
  chk_flash_input_read: assert property ( // [RULE3]
    rd1 && req[1].adr == clb_pkg::OFS_FLASH_PIN_INPUT
    |=> core1_wb_o.dat == {26'h0, $past(flash_pin_in_i)})
    else $error("flash input read wrong");
  chk_level_write_drive: assert property ( // [RULE4]
    solo0 && req[0].adr == clb_pkg::OFS_FLASH_PIN_LEVEL
    |=> flash_pin_level_o == $past(req[0].dat[5:0]))
    else $error("flash level write not driven");
  chk_level_readback: assert property ( // [RULE5]
    rd0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_LEVEL && !wr[1]
    |=> core0_wb_o.dat == {2'b00, main_pin_level_o})
    else $error("level readback wrong");
  chk_dual_write_order: assert property ( // [RULE6]
    full0 && full1 && req[0].adr == clb_pkg::OFS_MAIN_PIN_LEVEL
    && req[1].adr == clb_pkg::OFS_MAIN_PIN_LEVEL_TOGGLE
    |=> main_pin_level_o == ($past(req[0].dat[29:0]) ^ $past(req[1].dat[29:0])))
    else $error("dual write order wrong");
  chk_level_set: assert property ( // [RULE7]
    solo0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_LEVEL_SET
    |=> main_pin_level_o == ($past(main_pin_level_o) | $past(req[0].dat[29:0])))
    else $error("level set wrong");
  chk_level_clear: assert property ( // [RULE8]
    solo0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_LEVEL_CLEAR
    |=> main_pin_level_o == ($past(main_pin_level_o) & ~$past(req[0].dat[29:0])))
    else $error("level clear wrong");
  chk_level_toggle: assert property ( // [RULE9]
    solo0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_LEVEL_TOGGLE
    |=> main_pin_level_o == ($past(main_pin_level_o) ^ $past(req[0].dat[29:0])))
    else $error("level toggle wrong");
  chk_drive_reset: assert property ( // [RULE10]
    disable iff (1'b0) rst_i |=> main_pin_drive_enable_o == 30'h0)
    else $error("drive enable not reset");
  chk_drive_readback: assert property ( // [RULE11]
    rd1 && req[1].adr == clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE && !wr[0]
    |=> core1_wb_o.dat == {2'b00, main_pin_drive_enable_o})
    else $error("drive readback wrong");
  chk_drive_clear: assert property ( // [RULE12]
    solo0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE_CLEAR
    |=> main_pin_drive_enable_o
    == ($past(main_pin_drive_enable_o) & ~$past(req[0].dat[29:0])))
    else $error("drive clear wrong");
  chk_flash_toggle: assert property ( // [RULE13]
    solo0 && req[0].adr == clb_pkg::OFS_FLASH_PIN_LEVEL_TOGGLE
    |=> flash_pin_level_o == ($past(flash_pin_level_o) ^ $past(req[0].dat[5:0])))
    else $error("flash toggle wrong");
  chk_alias_reads_zero: assert property ( // [RULE14]
    rd0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_LEVEL_SET |=> core0_wb_o.dat == 32'h0)
    else $error("alias read not zero");
  chk_drive_set: assert property ( // [RULE12]
    solo0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE_SET
    |=> main_pin_drive_enable_o
    == ($past(main_pin_drive_enable_o) | $past(req[0].dat[29:0])))
    else $error("drive set wrong");
  chk_drive_toggle: assert property ( // [RULE12]
    solo0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE_TOGGLE
    |=> main_pin_drive_enable_o
    == ($past(main_pin_drive_enable_o) ^ $past(req[0].dat[29:0])))
    else $error("drive toggle wrong");
  chk_flash_set: assert property ( // [RULE13]
    solo0 && req[0].adr == clb_pkg::OFS_FLASH_PIN_LEVEL_SET
    |=> flash_pin_level_o == ($past(flash_pin_level_o) | $past(req[0].dat[5:0])))
    else $error("flash set wrong");
  chk_flash_clear: assert property ( // [RULE13]
    solo0 && req[0].adr == clb_pkg::OFS_FLASH_PIN_LEVEL_CLEAR
    |=> flash_pin_level_o == ($past(flash_pin_level_o) & ~$past(req[0].dat[5:0])))
    else $error("flash clear wrong");
  chk_drive_dual_order: assert property ( // [RULE6]
    full0 && full1 && req[0].adr == clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE_SET
    && req[1].adr == clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE_CLEAR
    |=> main_pin_drive_enable_o == (($past(main_pin_drive_enable_o)
    | $past(req[0].dat[29:0])) & ~$past(req[1].dat[29:0])))
    else $error("drive dual order wrong");
  chk_write_answer: assert property ( // [RULE14]
    wr[1] |=> core1_wb_o.dat == 32'h0)
    else $error("write answer data not zero");

  cov_dual_write: cover property (wr[0] && wr[1]);
  cov_core1_id: cover property (rd1 && req[1].adr == clb_pkg::OFS_CORE_IDENTITY);
  cov_toggle: cover property (solo0 && req[0].adr == clb_pkg::OFS_MAIN_PIN_LEVEL_TOGGLE);
  cov_drive_order: cover property (full0 && full1
    && req[0].adr == clb_pkg::OFS_MAIN_PIN_DRIVE_ENABLE_SET);
  cov_flash_read: cover property (rd1 && req[1].adr == clb_pkg::OFS_FLASH_PIN_INPUT);

endmodule

`default_nettype wire

/* File: design/clb_pkg.sv */
package clb_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned MAIN_W = 30;
  localparam int unsigned FLASH_W = 6;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CORE_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_MAIN_PIN_INPUT = 8'h04;
  localparam logic [7:0] OFS_FLASH_PIN_INPUT = 8'h08;
  localparam logic [7:0] OFS_MAIN_PIN_LEVEL = 8'h10;
  localparam logic [7:0] OFS_MAIN_PIN_LEVEL_SET = 8'h14;
  localparam logic [7:0] OFS_MAIN_PIN_LEVEL_CLEAR = 8'h18;
  localparam logic [7:0] OFS_MAIN_PIN_LEVEL_TOGGLE = 8'h1c;
  localparam logic [7:0] OFS_MAIN_PIN_DRIVE_ENABLE = 8'h20;
  localparam logic [7:0] OFS_MAIN_PIN_DRIVE_ENABLE_SET = 8'h24;
  localparam logic [7:0] OFS_MAIN_PIN_DRIVE_ENABLE_CLEAR = 8'h28;
  localparam logic [7:0] OFS_MAIN_PIN_DRIVE_ENABLE_TOGGLE = 8'h2c;
  localparam logic [7:0] OFS_FLASH_PIN_LEVEL = 8'h30;
  localparam logic [7:0] OFS_FLASH_PIN_LEVEL_SET = 8'h34;
  localparam logic [7:0] OFS_FLASH_PIN_LEVEL_CLEAR = 8'h38;
  localparam logic [7:0] OFS_FLASH_PIN_LEVEL_TOGGLE = 8'h3c;

  // ----------------------------------------
  // address fields: group in [7:4], alias in [3:2]
  // ----------------------------------------
  localparam logic [3:0] GRP_MAIN_LEVEL = 4'h1;
  localparam logic [3:0] GRP_MAIN_DRIVE = 4'h2;
  localparam logic [3:0] GRP_FLASH_LEVEL = 4'h3;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;
  localparam logic [1:0] OP_TOGGLE = 2'h3;

  // ----------------------------------------
  // values
  // ----------------------------------------
  localparam logic [31:0] CORE0_ID = 32'h0000_0000;
  localparam logic [31:0] CORE1_ID = 32'h0000_0001;
  localparam logic [31:0] MAIN_MASK = 32'h3fff_ffff;
  localparam logic [31:0] FLASH_MASK = 32'h0000_003f;
  localparam logic [31:0] LEVEL_RESET = 32'h0000_0000;
  localparam logic [31:0] DRIVE_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } clb_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } clb_wb_rsp_type;

  typedef enum logic [1:0] {
    CLB_IDLE = 2'b01,
    CLB_ACK = 2'b10
  } clb_bus_state_type;

endpackage

/* File: testbench/clb_core_master.sv */
`timescale 1ns/10ps
`default_nettype none

module clb_core_master (
  input wire logic clk_i,
  input wire clb_pkg::clb_wb_rsp_type rsp_i,
  output var clb_pkg::clb_wb_req_type req_o
);
  initial req_o = '0;

  // ----------------------------------------
  // one classic cycle, lines scrambled once released
  // ----------------------------------------
  task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
    @(posedge clk_i);
    req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do begin
      @(posedge clk_i);
    end while (rsp_i.ack !== 1'b1);
    req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~a, sel: ~s, dat: ~d};
    @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  clb_pkg::clb_wb_req_type req0;
  clb_pkg::clb_wb_req_type req1;
  clb_pkg::clb_wb_rsp_type rsp0;
  clb_pkg::clb_wb_rsp_type rsp1;
  logic [29:0] pin_m = 30'h0;
  logic [5:0] pin_f = 6'h0;
  logic [29:0] nm = 30'h0;
  logic [5:0] nf = 6'h0;
  logic [29:0] lvl_m;
  logic [29:0] oe_m;
  logic [5:0] lvl_f;
  logic [31:0] st [1:3];
  logic [31:0] q0 [$];
  logic [31:0] q1 [$];
  logic [15:0] lf = 16'h9627;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  clb_core_local_io u_clb_core_local_io (.clk_i(clk_i), .rst_i(rst_i),
    .core0_wb_i(req0), .core0_wb_o(rsp0), .core1_wb_i(req1), .core1_wb_o(rsp1),
    .main_pin_in_i(pin_m), .flash_pin_in_i(pin_f), .main_pin_level_o(lvl_m),
    .main_pin_drive_enable_o(oe_m), .flash_pin_level_o(lvl_f));
  clb_core_master u_clb_core_master_c0 (.clk_i(clk_i), .rsp_i(rsp0), .req_o(req0));
  clb_core_master u_clb_core_master_c1 (.clk_i(clk_i), .rsp_i(rsp1), .req_o(req1));

  // ----------------------------------------
  // reference
  // ----------------------------------------
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [31:0] rnd();
    logic [15:0] a;
    a = step(lf);
    lf = step(a);
    return {a, lf};
  endfunction

  function automatic logic [31:0] upd(input logic [31:0] c, input logic [1:0] op,
                                     input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    case (op)
      2'h0: return (c & ~m) | (d & m);
      2'h1: return c | (d & m);
      2'h2: return c & ~(d & m);
      default: return c ^ (d & m);
    endcase
  endfunction

  function automatic logic [31:0] rd_exp(input logic c, input logic [7:0] a);
    if (a[1:0] != 2'h0) return 32'h0;
    if (a == 8'h00) return {31'h0, c};
    if (a == 8'h04) return {2'h0, nm};
    if (a == 8'h08) return {26'h0, nf};
    if (a[3:0] == 4'h0 && a[7:4] >= 4'h1 && a[7:4] <= 4'h3) return st[a[7:4]];
    return 32'h0;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    if (a[1:0] == 2'h0 && a[7:4] >= 4'h1 && a[7:4] <= 4'h3)
      st[a[7:4]] = upd(st[a[7:4]], a[3:2], d, s) & (a[7:4] == 4'h3 ? 32'h3f : 32'h3fff_ffff);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic pins();
    @(negedge clk_i);
    check("main_level", {2'h0, lvl_m}, st[1]);
    check("main_drive", {2'h0, oe_m}, st[2]);
    check("flash_level", {26'h0, lvl_f}, st[3]);
  endtask

  // note expectations, then run the enabled cores in the same cycle
  task automatic go(input logic e0, e1, w0, w1, input logic [7:0] a0, a1,
                    input logic [3:0] s, input logic [31:0] d0, d1);
    logic [31:0] r;
    @(posedge clk_i);
    r = rnd();
    nm = r[29:0];
    nf = r[31:26];
    pin_m <= nm;
    pin_f <= nf;
    if (e0) q0.push_back(w0 ? 32'h0 : rd_exp(1'b0, a0));
    if (e1) q1.push_back(w1 ? 32'h0 : rd_exp(1'b1, a1));
    if (e0 && w0) wr(a0, s, d0);
    if (e1 && w1) wr(a1, s, d1);
    fork
      if (e0) u_clb_core_master_c0.xfer(w0, a0, s, d0);
      if (e1) u_clb_core_master_c1.xfer(w1, a1, s, d1);
    join
    pins();
  endtask

  // ----------------------------------------
  // answer monitor and timeout
  // ----------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      close_out();
    end else if (!rst_i) begin
      if (rsp0.ack === 1'b1) begin
        if (q0.size() == 0) check("core0_ack", 32'h1, 32'h0);
        else check("core0_data", rsp0.dat, q0.pop_front());
      end
      if (rsp1.ack === 1'b1) begin
        if (q1.size() == 0) check("core1_ack", 32'h1, 32'h0);
        else check("core1_data", rsp1.dat, q1.pop_front());
      end
    end
  end

  initial begin
    logic [31:0] r;
    logic [7:0] a0;
    logic [7:0] a1;
    st[1] = 32'h0;
    st[2] = 32'h0;
    st[3] = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    pins();
    for (int a = 0; a <= 8'h44; a += 4) begin
      go(1'b1, 1'b1, 1'b0, 1'b0, a[7:0], a[7:0], 4'hf, 32'h0, 32'h0);
    end
    go(1'b1, 1'b1, 1'b1, 1'b1, 8'h10, 8'h20, 4'hf, 32'hffff_ffff, 32'hffff_ffff);
    go(1'b1, 1'b1, 1'b1, 1'b1, 8'h30, 8'h04, 4'hf, 32'hffff_ffff, 32'h0);
    go(1'b1, 1'b1, 1'b1, 1'b1, 8'h11, 8'h40, 4'hf, 32'h0, 32'h0);
    go(1'b1, 1'b1, 1'b0, 1'b0, 8'h30, 8'h10, 4'hf, 32'h0, 32'h0);
    for (int g = 1; g <= 3; g++) begin
      for (int o0 = 0; o0 < 4; o0++) begin
        for (int o1 = 0; o1 < 4; o1++) begin
          r = rnd();
          a0 = {g[3:0], o0[1:0], 2'h0};
          a1 = {g[3:0], o1[1:0], 2'h0};
          go(1'b1, 1'b1, 1'b1, 1'b1, a0, a1, (o0 == o1) ? r[3:0] : 4'hf, rnd(), rnd());
          go(1'b1, 1'b1, 1'b0, 1'b1, {g[3:0], 4'h0}, a1, 4'hf, 32'h0, rnd());
          go(1'b0, 1'b1, 1'b0, 1'b0, 8'h0, {g[3:0], 4'h0}, 4'hf, 32'h0, 32'h0);
          go(1'b1, 1'b0, 1'b1, 1'b0, a0, 8'h0, 4'hf, rnd(), 32'h0);
        end
      end
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    st[1] = 32'h0;
    st[2] = 32'h0;
    st[3] = 32'h0;
    pins();
    go(1'b1, 1'b1, 1'b0, 1'b0, 8'h20, 8'h30, 4'hf, 32'h0, 32'h0);
    repeat (4) @(posedge clk_i);
    check("pending", 32'(q0.size() + q1.size()), 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
